// [common/lpl_defines.vh]
// constants for the load protection latch controller
`ifndef LPL_DEFINES_VH
`define LPL_DEFINES_VH
// status word bit positions
`define LPL_BIT_VOLT 0
`define LPL_BIT_CURR 1
`define LPL_BIT_PWR 2
`define LPL_BIT_TEMP 3
`define LPL_BIT_REV 4
`define LPL_BIT_VSUM 5
`define LPL_BIT_PSUM 6
`define LPL_STAT_W 7
`define LPL_STAT_RST 7'h00
// display codes
`define LPL_DISP_NONE 3'h0
`define LPL_DISP_VOLT 3'h1
`define LPL_DISP_CURR 3'h2
`define LPL_DISP_PWR 3'h3
`define LPL_DISP_TEMP 3'h4
`define LPL_DISP_REV 3'h5
// timing
`define LPL_CLK_NS 10
`define LPL_BEEP_US 100
`define LPL_BEEP_CYC ((`LPL_BEEP_US * 1000) / `LPL_CLK_NS)
`define LPL_CURR_DLY_RST 16'h0064
`define LPL_CURR_LIM_RST 16'hffff
`endif

// [rtl/lpl_ctrl.v]
// load protection latch controller: fault latching, status, trigger and config bits
// Operation
// - a trip sets fault bit, turns input off, beeps, lights clear, shows code, latches
// - while latched, all commands except protection clear are ignored, though a key press still sounds its click
// - only a clear request (key or remote) leaves the latched state
// - a clear with the fault still present latches again at once
// - over-voltage turns input off, shows code, sets voltage flag and voltage summary
// - a fault bit clears only after a clear request and the condition gone
// - over-limit current starts the delay timer and lights clear, input stays on
// - timer reaching delay turns input off, sets current flag and protection summary
// - over-current has enable, limit level and delay settings
// - clear while timer runs untripped restarts the accumulated time, input stays on
// - power above rating is timed; trip only after time exceeds the limit
// - over-power trip turns input off, sets power flag and protection summary
// - over-temperature turns input off, sets temperature flag and protection summary
// - reverse voltage turns input off, lights clear, sets reverse flag and voltage summary
// - status is readable; an enable word picks which events are reported
// - trigger target routes triggers to transient or sequence operation
// - knob enable bit; disabled knob movements are ignored
// - key sound enable bit gates the key click
// - external trigger fires on a falling edge of its input
`include "lpl_defines.vh"
module lpl_ctrl #(
   parameter BEEP_CYC = `LPL_BEEP_CYC
) (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   // raw fault conditions
   input wire volt_cond,
   input wire curr_cond,
   input wire pwr_cond,
   input wire temp_cond,
   input wire rev_cond,
   // over-current settings, delay in clock ticks
   input wire curr_prot_enable,
   input wire [15:0] curr_limit,
   input wire [15:0] curr_delay,
   input wire [15:0] meas_current,
   // over-power time limit in clock ticks
   input wire [15:0] pwr_time_limit,
   // commands from panel or remote
   input wire clear_req,
   input wire input_on_req,
   input wire input_off_req,
   input wire key_press,
   input wire knob_step,
   input wire knob_dir,
   // configuration
   input wire trig_target_list,
   input wire knob_enable,
   input wire key_sound_enable,
   input wire [`LPL_STAT_W-1:0] status_enable,
   // external trigger pin
   input wire ext_trig_n,
   // outputs
   output reg load_input_on,
   output reg beep,
   output reg clear_indicator,
   output reg protection_latched,
   output reg [2:0] protection_display_code,
   output wire [`LPL_STAT_W-1:0] status_word,
   output reg [`LPL_STAT_W-1:0] status_event,
   output reg trig_transient,
   output reg trig_sequence,
   output reg knob_up,
   output reg knob_down,
   output reg key_click
);

////////////////////////////////////////////////////////////////////////////////
// sizes and fixed values
localparam BEEP_W = 24;
localparam [BEEP_W-1:0] BEEP_LOAD = BEEP_CYC[BEEP_W-1:0];
localparam NFLT = 5;
localparam [15:0] TIMER_MAX = 16'hffff;
localparam [BEEP_W-1:0] BEEP_ONE = {{(BEEP_W-1){1'b0}}, 1'b1};
localparam [BEEP_W-1:0] BEEP_ZERO = {BEEP_W{1'b0}};

////////////////////////////////////////////////////////////////////////////////
// internal signals
wire [NFLT-1:0] raw_fault;
wire [NFLT-1:0] fault_sync;
reg trig_meta;
reg trig_sync;
reg trig_prev;
wire trig_fall;
wire volt_s;
wire curr_s;
wire pwr_s;
wire temp_s;
wire rev_s;
reg [15:0] curr_timer;
reg [15:0] pwr_timer;
reg [15:0] next_curr_timer;
reg [15:0] next_pwr_timer;
wire curr_over;
wire curr_trip_now;
wire pwr_trip_now;
wire [NFLT-1:0] trip;
wire [NFLT-1:0] cond;
wire [NFLT-1:0] flags;
wire [NFLT-1:0] next_flags;
wire overvoltage_flag;
wire overcurrent_flag;
wire overpower_flag;
wire overtemp_flag;
wire reverse_voltage_flag;
wire voltage_fault_summary;
wire protection_summary;
wire next_voltage_fault_summary;
wire next_protection_summary;
wire any_trip;
wire next_latched;
wire commands_open;
reg next_input_on;
reg [2:0] next_display_code;
reg [BEEP_W-1:0] beep_cnt;
reg [BEEP_W-1:0] next_beep_cnt;
reg next_beep;
genvar gi;

////////////////////////////////////////////////////////////////////////////////
// synchronisers: the first stage is read only by the second
// faults reset to their idle level, so nothing trips in the two edges after reset
// a condition shorter than one clock may be missed; the causes are slow levels
assign raw_fault = {rev_cond, temp_cond, pwr_cond, curr_cond, volt_cond};

generate
   for (gi = 0; gi < NFLT; gi = gi + 1) begin : g_sync
      reg meta;
      reg sync;
      always @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            meta <= 1'b0;
            sync <= 1'b0;
         end else begin
            meta <= raw_fault[gi];
            sync <= meta;
         end
      end
      assign fault_sync[gi] = sync;
   end
endgenerate

// the trigger idles high, so its chain resets high and no false edge follows reset
always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      trig_meta <= 1'b1;
      trig_sync <= 1'b1;
      trig_prev <= 1'b1;
   end else begin
      trig_meta <= ext_trig_n;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
   end
end

assign trig_fall = trig_prev & ~trig_sync;
assign volt_s = fault_sync[`LPL_BIT_VOLT];
assign curr_s = fault_sync[`LPL_BIT_CURR];
assign pwr_s = fault_sync[`LPL_BIT_PWR];
assign temp_s = fault_sync[`LPL_BIT_TEMP];
assign rev_s = fault_sync[`LPL_BIT_REV];

////////////////////////////////////////////////////////////////////////////////
// over-current and over-power timers
// the timers count clock ticks, the same unit as their settings
assign curr_over = curr_prot_enable & curr_s & (meas_current > curr_limit);
assign curr_trip_now = curr_over & (curr_timer >= curr_delay);
assign pwr_trip_now = pwr_s & (pwr_timer > pwr_time_limit);

// both timers saturate rather than wrap, so a long fault never looks short
always @* begin
   next_curr_timer = curr_timer;
   if (!curr_over || (clear_req && !curr_trip_now)) begin
      next_curr_timer = 16'h0000;
   end else if (curr_timer != TIMER_MAX) begin
      next_curr_timer = curr_timer + 16'h0001;
   end
end

always @* begin
   next_pwr_timer = pwr_timer;
   if (!pwr_s) begin
      next_pwr_timer = 16'h0000;
   end else if (pwr_timer != TIMER_MAX) begin
      next_pwr_timer = pwr_timer + 16'h0001;
   end
end

always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      curr_timer <= 16'h0000;
      pwr_timer <= 16'h0000;
   end else begin
      curr_timer <= next_curr_timer;
      pwr_timer <= next_pwr_timer;
   end
end

////////////////////////////////////////////////////////////////////////////////
// fault flags, one per cause
assign trip = {rev_s, temp_s, pwr_trip_now, curr_trip_now, volt_s};
assign cond = {rev_s, temp_s, pwr_s, curr_over, volt_s};
assign any_trip = |trip;

generate
   for (gi = 0; gi < NFLT; gi = gi + 1) begin : g_flag
      reg flag;
      // a flag drops only on a clear with its cause gone; a trip always wins
      wire next_flag = trip[gi] | (flag & ~(clear_req & ~cond[gi]));
      always @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            flag <= 1'b0;
         end else begin
            flag <= next_flag;
         end
      end
      assign flags[gi] = flag;
      assign next_flags[gi] = next_flag;
   end
endgenerate

assign overvoltage_flag = flags[`LPL_BIT_VOLT];
assign overcurrent_flag = flags[`LPL_BIT_CURR];
assign overpower_flag = flags[`LPL_BIT_PWR];
assign overtemp_flag = flags[`LPL_BIT_TEMP];
assign reverse_voltage_flag = flags[`LPL_BIT_REV];
assign voltage_fault_summary = overvoltage_flag | reverse_voltage_flag;
assign protection_summary = overcurrent_flag | overpower_flag | overtemp_flag;
assign next_voltage_fault_summary = next_flags[`LPL_BIT_VOLT] | next_flags[`LPL_BIT_REV];
assign next_protection_summary = next_flags[`LPL_BIT_CURR] | next_flags[`LPL_BIT_PWR]
                                 | next_flags[`LPL_BIT_TEMP];
assign status_word = {protection_summary, voltage_fault_summary, flags};

////////////////////////////////////////////////////////////////////////////////
// latch and command gate
// latched state persists until a clear finds every trip gone
assign next_latched = any_trip | (protection_latched & ~clear_req);
// commands are ignored in the trip cycle, while latched and in the clearing cycle
assign commands_open = ~any_trip & ~next_latched & ~protection_latched;

always @* begin
   next_input_on = load_input_on;
   if (any_trip) begin
      next_input_on = 1'b0;
   end else if (commands_open) begin
      if (input_off_req) begin
         next_input_on = 1'b0;
      end else if (input_on_req) begin
         next_input_on = 1'b1;
      end
   end
end

// several trips in one cycle show one code: voltage first, current last
always @* begin
   next_display_code = protection_display_code;
   if (trip[`LPL_BIT_VOLT]) begin
      next_display_code = `LPL_DISP_VOLT;
   end else if (trip[`LPL_BIT_REV]) begin
      next_display_code = `LPL_DISP_REV;
   end else if (trip[`LPL_BIT_TEMP]) begin
      next_display_code = `LPL_DISP_TEMP;
   end else if (trip[`LPL_BIT_PWR]) begin
      next_display_code = `LPL_DISP_PWR;
   end else if (trip[`LPL_BIT_CURR]) begin
      next_display_code = `LPL_DISP_CURR;
   end else if (!next_latched) begin
      next_display_code = `LPL_DISP_NONE;
   end
end

// a relatch while already latched does not restart the beep
always @* begin
   next_beep_cnt = beep_cnt;
   next_beep = 1'b0;
   if (any_trip && !protection_latched) begin
      next_beep_cnt = BEEP_LOAD;
      next_beep = 1'b1;
   end else if (beep_cnt != BEEP_ZERO) begin
      next_beep_cnt = beep_cnt - BEEP_ONE;
      next_beep = (beep_cnt != BEEP_ONE);
   end
end

// the event word carries the next state, so it never lags the status word
always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      protection_latched <= 1'b0;
      protection_display_code <= `LPL_DISP_NONE;
      load_input_on <= 1'b0;
      clear_indicator <= 1'b0;
      beep <= 1'b0;
      beep_cnt <= BEEP_ZERO;
      status_event <= `LPL_STAT_RST;
   end else begin
      protection_latched <= next_latched;
      protection_display_code <= next_display_code;
      load_input_on <= next_input_on;
      // the clear lamp also shows a running, untripped over-current timer
      clear_indicator <= next_latched | (curr_over & ~clear_req);
      beep <= next_beep;
      beep_cnt <= next_beep_cnt;
      status_event <= {next_protection_summary, next_voltage_fault_summary, next_flags}
                      & status_enable;
   end
end

////////////////////////////////////////////////////////////////////////////////
// auxiliary: trigger routing and knob blocked while latched
always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      trig_transient <= 1'b0;
      trig_sequence <= 1'b0;
   end else begin
      trig_transient <= trig_fall & ~trig_target_list & ~protection_latched;
      trig_sequence <= trig_fall & trig_target_list & ~protection_latched;
   end
end

always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      knob_up <= 1'b0;
      knob_down <= 1'b0;
   end else begin
      knob_up <= knob_step & knob_dir & knob_enable & ~protection_latched;
      knob_down <= knob_step & ~knob_dir & knob_enable & ~protection_latched;
   end
end

// the key click is panel feedback, so it still sounds while latched
always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      key_click <= 1'b0;
   end else begin
      key_click <= key_press & key_sound_enable;
   end
end

endmodule

// [testbench/lpl_ctrl_props.sv]
// concurrent checks on the protection latch controller ports
`include "lpl_defines.vh"
module lpl_ctrl_props (
   // watched inputs and outputs, several to a line to keep the checker short
   input wire core_clk, nrst, volt_cond, temp_cond, rev_cond, input_on_req, clear_req,
   input wire knob_step, knob_dir, knob_enable, key_press, key_sound_enable,
   input wire load_input_on, beep, clear_indicator, protection_latched,
   input wire trig_transient, trig_sequence, knob_up, key_click,
   input wire [2:0] protection_display_code,
   input wire [`LPL_STAT_W-1:0] status_enable, status_word, status_event
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   a_trip_marks:
      assert property ($rose(protection_latched) |-> beep && clear_indicator && !load_input_on
         && protection_display_code != `LPL_DISP_NONE) else $error("trip marks missing");
   a_on_refused:
      assert property (protection_latched && input_on_req |=> !load_input_on)
      else $error("input turned on while latched");
   a_latch_mute:
      assert property ($past(protection_latched) && protection_latched |->
         !trig_transient && !trig_sequence && !knob_up) else $error("event while latched");
   // four samples leave room for the two-flop synchroniser and the trip edge
   a_ov_trip:
      assert property (volt_cond [*4] |=> status_word[0] && status_word[5] && !load_input_on)
      else $error("over-voltage not latched");
   a_flag_sticky:
      assert property ($fell(status_word[0]) |-> $past(clear_req)) else $error("flag fell alone");
   a_ot_trip:
      assert property (temp_cond [*4] |=> status_word[3] && status_word[6] && !load_input_on)
      else $error("over-temperature not latched");
   a_rv_trip:
      assert property (rev_cond [*4] |=> status_word[4] && status_word[5] && clear_indicator)
      else $error("reverse voltage not latched");
   a_event_mask:
      assert property (status_event == (status_word & $past(status_enable)))
      else $error("event word not masked status");
   a_knob_cause:
      assert property (knob_up |-> $past(knob_step && knob_dir && knob_enable))
      else $error("knob step without cause");
   a_click_cause:
      assert property (key_click |-> $past(key_press && key_sound_enable))
      else $error("click without cause");
   a_trig_pulse:
      assert property (trig_transient |=> !trig_transient) else $error("trigger not one cycle");
   cover property ($rose(protection_latched));
   cover property (trig_sequence);
   cover property (knob_up);
endmodule
bind lpl_ctrl lpl_ctrl_props u_lpl_ctrl_props (.*);

// [testbench/lpl_panel.sv]
// front panel and remote controller model: clear requests and trigger pin
module lpl_panel (
   input logic core_clk,
   output logic clear_req,
   output logic ext_trig_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      clear_req = 0;
      ext_trig_n = 1;
   end
   // a long key press reaches the block as one request pulse
   task automatic clear_pulse();
      @(negedge core_clk) clear_req = 1;
      @(negedge core_clk) clear_req = 0;
   endtask
   // falling edge only, held low past the synchroniser
   task automatic trig_fall();
      @(negedge core_clk) ext_trig_n = 0;
      repeat (4) @(negedge core_clk);
      ext_trig_n = 1;
   endtask
endmodule

// [testbench/lpl_ctrl_bench.sv]
// self-checking bench for the protection latch controller
`include "lpl_defines.vh"
module lpl_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, nrst = 0, curr_prot_enable = 0, clear_req, ext_trig_n, knob_down, beep;
   logic input_on_req = 0, input_off_req = 0, key_press = 0, knob_step = 0, knob_dir = 0;
   logic trig_target_list = 0, knob_enable = 0, key_sound_enable = 0, load_input_on;
   logic clear_indicator, protection_latched, trig_transient, trig_sequence, knob_up, key_click;
   logic [4:0] cnd = 0;
   logic [15:0] curr_limit = 16'h0100, curr_delay = 16'h0006, meas_current = 0;
   logic [15:0] pwr_time_limit = 16'h0004;
   logic [6:0] status_enable = 0, status_word, status_event;
   logic [2:0] protection_display_code;
   int fails = 0, compares = 0, cyc = 0, n_tt, n_ts, n_ku, n_kd, n_kc;
   initial forever #5 core_clk = ~core_clk;
   lpl_ctrl #(.BEEP_CYC(4)) u_lpl_ctrl (.volt_cond(cnd[0]), .curr_cond(cnd[1]),
      .pwr_cond(cnd[2]), .temp_cond(cnd[3]), .rev_cond(cnd[4]), .*);
   lpl_panel u_lpl_panel (.core_clk(core_clk), .clear_req(clear_req), .ext_trig_n(ext_trig_n));
   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cyc++;
      n_tt += trig_transient;
      n_ts += trig_sequence;
      n_ku += knob_up;
      n_kd += knob_down;
      n_kc += key_click;
      if (cyc == 6000) begin
         fails++;
         test_done();
      end
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask
   function automatic logic [6:0] exp_stat(int i);
      return (7'h01 << i) | ((i == 0 || i == 4) ? 7'h20 : 7'h40);
   endfunction
   task automatic test_done();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // trip, refuse, relatch while present, stay sticky, then clear
   task automatic fault(int i);
      status_enable = 7'($urandom);
      pwr_time_limit = 16'($urandom_range(4, 10));
      pulse(input_on_req);
      chk("on", 1, load_input_on);
      cnd[i] = 1;
      tick(3);
      if (i == 2) chk("pwr_wait", 0, protection_latched);
      chk("beep", i != 2, beep);
      tick(pwr_time_limit + 8);
      chk("stat", exp_stat(i), status_word);
      chk("code", i + 1, protection_display_code);
      pulse(input_on_req);
      u_lpl_panel.clear_pulse();
      tick(2);
      chk("relatch", 2'b10, {protection_latched, load_input_on});
      cnd[i] = 0;
      tick(5);
      chk("sticky", exp_stat(i), status_word);
      u_lpl_panel.clear_pulse();
      tick(2);
      chk("cleared", 0, {protection_latched, status_word});
      $display("fault %0d done", i);
   endtask
   initial begin
      void'($urandom(32'h66518dff));
      tick(6);
      nrst = 1;
      tick(3);
      chk("reset", 0, {load_input_on, protection_latched, status_word});
      for (int i = 0; i < 5; i++) if (i != 1) fault(i);
      curr_prot_enable = 1;
      meas_current = 16'h0200;
      curr_delay = 16'($urandom_range(6, 12));
      pulse(input_on_req);
      cnd[1] = 1;
      tick(5);
      chk("curr_run", 3'b101, {clear_indicator, protection_latched, load_input_on});
      u_lpl_panel.clear_pulse();
      tick(3);
      chk("curr_rst", 2'b01, {protection_latched, load_input_on});
      tick(curr_delay + 4);
      chk("curr_trip", 7'h42, status_word);
      chk("curr_code", 2, protection_display_code);
      cnd[1] = 0;
      tick(4);
      u_lpl_panel.clear_pulse();
      curr_prot_enable = 0;
      cnd[1] = 1;
      tick(curr_delay + 10);
      chk("curr_off", 0, protection_latched);
      cnd[1] = 0;
      $display("over-current done");
      for (int k = 0; k < 8; k++) begin
         trig_target_list = 1'($urandom);
         knob_enable = 1'($urandom);
         knob_dir = 1'($urandom);
         key_sound_enable = 1'($urandom);
         {n_tt, n_ts, n_ku, n_kd, n_kc} = 0;
         u_lpl_panel.trig_fall();
         pulse(knob_step);
         pulse(key_press);
         tick(4);
         chk("tran", !trig_target_list, n_tt);
         chk("seq", trig_target_list, n_ts);
         chk("knob", knob_enable & knob_dir, n_ku);
         chk("knob_dn", knob_enable & !knob_dir, n_kd);
         chk("click", key_sound_enable, n_kc);
      end
      $display("auxiliary done");
      test_done();
   end
endmodule
